// ==== src/blsfs_pkg.sv ====
// Package for the bus-limit and short fault status block: offsets, field layout, reset values, carrier types.
// Assumes register offsets are PMBus command codes, one byte per register.
package blsfs_pkg;

  // Command codes of the two status registers
  localparam logic [7:0] LIMIT_ADDR = 8'hd7;
  localparam logic [7:0] SHORT_ADDR = 8'hd8;

  // Field widths
  localparam int LIMIT_W = 8;
  localparam int SHORT_W = 5;
  localparam int REG_W   = 8;

  // Reset values
  localparam logic [LIMIT_W-1:0] LIMIT_RST = 8'h00;
  localparam logic [SHORT_W-1:0] SHORT_RST = 5'h00;

  // Limit register bit positions
  localparam int LV_OUT_OV = 0;
  localparam int LV_OUT_UV = 1;
  localparam int LV_IN_OV  = 2;
  localparam int LV_IN_UV  = 3;
  localparam int HV_OUT_OV = 4;
  localparam int HV_OUT_UV = 5;
  localparam int HV_IN_OV  = 6;
  localparam int HV_IN_UV  = 7;

  // Short register bit positions
  localparam int HS_SHORT     = 0;
  localparam int LV_GND_SHORT = 1;
  localparam int LS_SHORT     = 2;
  localparam int HV_GND_SHORT = 3;
  localparam int FB_SHORT     = 4;

  // Limit flags that only count in step-up operation; the rest count in step-down
  localparam logic [LIMIT_W-1:0] STEPUP_MASK = 8'hbc;

  // Raw detector levels as they arrive from the analog protection circuits
  typedef struct packed {
    logic [LIMIT_W-1:0] limit;
    logic [SHORT_W-1:0] short;
    logic               stepUp;
  } blsfs_det_t;

endpackage

// ==== src/blsfs_sticky_flags.sv ====
// Sticky flag vector: hardware sets, a clear request drops bits, a set wins over a clear.
// Assumes set and clear requests come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module blsfs_sticky_flags #(
  parameter int               WIDTH = 8,
  parameter logic [WIDTH-1:0] RST   = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Requests
  input  wire logic [WIDTH-1:0] setReq,
  input  wire logic [WIDTH-1:0] clrReq,
  // State
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] next_flags;

  // Set after clear so a fault in the clearing cycle is kept
  assign next_flags = (flags & ~clrReq) | setReq;

  // Flag storage
  always_ff @(posedge clk)
  begin
    if (!resetn)
      flags <= RST;
    else
      flags <= next_flags;
  end

endmodule // blsfs_sticky_flags

`default_nettype wire

// ==== src/blsfs_fault_status.sv ====
// Bus voltage limit and serious short fault status registers with a byte register port.
// Assumes detector and direction inputs are asynchronous levels; register port is on clk.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Step-down low bus output overvoltage sets bit0
// - Step-down low bus output undervoltage sets bit1
// - Step-up low bus input overvoltage sets bit2
// - Step-up low bus input undervoltage sets bit3
// - Step-up high bus output overvoltage sets bit4
// - Step-up high bus output undervoltage sets bit5
// - Step-down high bus input overvoltage sets bit6
// - Step-up high bus input undervoltage sets bit7
// - Byte registers, read/write, protectable, reset zero
// - High-side switch short sets short bit0
// - Short bits 1-4 as listed, 7-5 read zero
// - Low bus ground short sets short bit1
module blsfs_fault_status (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // Detector levels and direction, asynchronous
  input  wire logic [blsfs_pkg::LIMIT_W-1:0] limitDet,
  input  wire logic [blsfs_pkg::SHORT_W-1:0] shortDet,
  input  wire logic                      stepUpMode,
  // Write protection level from the device, same clock
  input  wire logic                      writeProtect,
  // Register port
  input  wire logic [7:0]                regAddr,
  input  wire logic                      regWrEn,
  input  wire logic [blsfs_pkg::REG_W-1:0]   regWrData,
  input  wire logic                      regRdEn,
  output logic      [blsfs_pkg::REG_W-1:0]   regRdData,
  output logic                           regRdValid,
  // Status
  output logic                           faultPending
);

  blsfs_pkg::blsfs_det_t detMeta;
  blsfs_pkg::blsfs_det_t detSync;
  logic [blsfs_pkg::LIMIT_W-1:0] limitFlags;
  logic [blsfs_pkg::SHORT_W-1:0] shortFlags;

  // Per-bit enable of limit detectors for the present direction
  function automatic logic [blsfs_pkg::LIMIT_W-1:0] modeMask(input logic stepUp);
    modeMask = stepUp ? blsfs_pkg::STEPUP_MASK : ~blsfs_pkg::STEPUP_MASK;
  endfunction

  // Address match, shared by read and write decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] code);
    hit = (addr == code);
  endfunction

  // Two-flop synchroniser; only the second stage is read
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      detMeta <= '0;
      detSync <= '0;
    end
    else
    begin
      detMeta <= '{limit: limitDet, short: shortDet, stepUp: stepUpMode};
      detSync <= detMeta;
    end
  end

  wire [blsfs_pkg::LIMIT_W-1:0] limitEnable = modeMask(detSync.stepUp);
  wire [blsfs_pkg::LIMIT_W-1:0] limitSet    = detSync.limit & limitEnable;
  wire [blsfs_pkg::SHORT_W-1:0] shortSet    = detSync.short;

  // Writes are dropped while protected; a written zero clears, a written one does nothing
  wire wrLimit = regWrEn && !writeProtect && hit(regAddr, blsfs_pkg::LIMIT_ADDR);
  wire wrShort = regWrEn && !writeProtect && hit(regAddr, blsfs_pkg::SHORT_ADDR);
  wire [blsfs_pkg::LIMIT_W-1:0] limitClr = wrLimit ? ~regWrData : '0;
  wire [blsfs_pkg::SHORT_W-1:0] shortClr = wrShort ? ~regWrData[blsfs_pkg::SHORT_W-1:0] : '0;

  // Limit flags, bit order fixed by the package positions
  blsfs_sticky_flags #(
    .WIDTH (blsfs_pkg::LIMIT_W),
    .RST   (blsfs_pkg::LIMIT_RST)
  ) uLimit (
    .clk    (clk),
    .resetn (resetn),
    .setReq (limitSet),
    .clrReq (limitClr),
    .flags  (limitFlags)
  );

  // Short flags; reserved bits have no storage at all
  blsfs_sticky_flags #(
    .WIDTH (blsfs_pkg::SHORT_W),
    .RST   (blsfs_pkg::SHORT_RST)
  ) uShort (
    .clk    (clk),
    .resetn (resetn),
    .setReq (shortSet),
    .clrReq (shortClr),
    .flags  (shortFlags)
  );

  // Read mux; unmapped codes read zero
  wire [blsfs_pkg::REG_W-1:0] shortByte = {3'h0, shortFlags};
  wire [blsfs_pkg::REG_W-1:0] rdMux =
    hit(regAddr, blsfs_pkg::LIMIT_ADDR) ? limitFlags :
    hit(regAddr, blsfs_pkg::SHORT_ADDR) ? shortByte : 8'h00;

  // Registered read answer and summary
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      regRdData    <= 8'h00;
      regRdValid   <= 1'b0;
      faultPending <= 1'b0;
    end
    else
    begin
      regRdData    <= regRdEn ? rdMux : regRdData;
      regRdValid   <= regRdEn;
      faultPending <= (|limitFlags) || (|shortFlags);
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_LV_OUT_OV: assert property (detSync.limit[0] && !detSync.stepUp |=> limitFlags[0])
    else $error("low bus output overvoltage not flagged");
  AST_LV_OUT_UV: assert property (detSync.limit[1] && !detSync.stepUp |=> limitFlags[1])
    else $error("low bus output undervoltage not flagged");
  AST_LV_IN_OV: assert property (detSync.limit[2] && detSync.stepUp |=> limitFlags[2])
    else $error("low bus input overvoltage not flagged");
  AST_LV_IN_UV: assert property (detSync.limit[3] && detSync.stepUp |=> limitFlags[3])
    else $error("low bus input undervoltage not flagged");
  AST_HV_OUT_OV: assert property (detSync.limit[4] && detSync.stepUp |=> limitFlags[4])
    else $error("high bus output overvoltage not flagged");
  AST_HV_OUT_UV: assert property (detSync.limit[5] && detSync.stepUp |=> limitFlags[5])
    else $error("high bus output undervoltage not flagged");
  AST_HV_IN_OV: assert property (detSync.limit[6] && !detSync.stepUp |=> limitFlags[6])
    else $error("high bus input overvoltage not flagged");
  AST_HV_IN_UV: assert property (detSync.limit[7] && detSync.stepUp |=> limitFlags[7])
    else $error("high bus input undervoltage not flagged");
  // Pin high for three edges: meta, sync, then the flag shows after the third
  AST_PIN_TO_FLAG: assert property ($rose(shortDet[0]) ##1 shortDet[0] ##1 shortDet[0] |=> shortFlags[0])
    else $error("high-side short not flagged three edges after pin");
  // Summary follows the flag one edge later, so the host sees it without a read
  AST_LV_GND: assert property (detSync.short[1] |=> shortFlags[1] ##1 faultPending)
    else $error("low bus ground short not flagged");
  AST_RESERVED: assert property (regRdValid && $past(regRdEn && hit(regAddr, blsfs_pkg::SHORT_ADDR))
                                 |-> regRdData[7:5] == 3'h0)
    else $error("reserved short bits read nonzero");
  // Reset edge clears every flag, the read valid and the summary; checked even while reset is low
  AST_RESET: assert property (@(posedge clk) disable iff (1'b0)
                              !resetn |=> limitFlags == 8'h00 && shortFlags == 5'h00
                                          && !regRdValid && !faultPending)
    else $error("flags not zero after reset");
  AST_PROTECT: assert property ($past(writeProtect) |-> ($past(limitFlags) & ~limitFlags) == 8'h00)
    else $error("protected write cleared a flag");
  AST_STICKY: assert property ((($past(limitFlags) & ~$past(limitClr)) & ~limitFlags) == 8'h00)
    else $error("limit flag dropped without clearing write");
  AST_DIR_GATE: assert property (((~$past(limitFlags) & ~$past(limitEnable)) & limitFlags) == 8'h00)
    else $error("limit flag set in wrong direction");

  // Direction must ride the same two-flop path as the detectors, or a mode change
  // could gate a detector level that belongs to the other direction
  AST_SYNC_DIR: assert property (detSync.stepUp == $past(stepUpMode, 2))
    else $error("direction not aligned with detector sync");

  // Remaining short detectors reach their own flag one edge after the synchroniser
  AST_HS_SHORT: assert property (detSync.short[0] |=> shortFlags[0])
    else $error("high-side short not flagged");
  AST_LS_SHORT: assert property (detSync.short[2] |=> shortFlags[2])
    else $error("low-side short not flagged");
  AST_HV_GND: assert property (detSync.short[3] |=> shortFlags[3])
    else $error("high bus ground short not flagged");
  AST_FB_SHORT: assert property (detSync.short[4] |=> shortFlags[4])
    else $error("flyback short not flagged");

  // Short flags are sticky too; only a clearing write may drop one
  AST_SHORT_STICKY: assert property ((($past(shortFlags) & ~$past(shortClr)) & ~shortFlags) == 5'h00)
    else $error("short flag dropped without clearing write");

  // Read answer: exactly one valid pulse, one edge after the strobe
  AST_RD_PULSE: assert property (regRdValid == $past(regRdEn))
    else $error("read valid not one edge after strobe");
  // Read data is the register as it stood at the taking edge
  AST_RD_LIMIT: assert property (regRdEn && hit(regAddr, blsfs_pkg::LIMIT_ADDR)
                                 |=> regRdData == $past(limitFlags))
    else $error("limit register read wrong");
  AST_RD_SHORT: assert property (regRdEn && hit(regAddr, blsfs_pkg::SHORT_ADDR)
                                 |=> regRdData == {3'h0, $past(shortFlags)})
    else $error("short register read wrong");

  // Summary is a registered copy of any flag being set
  AST_SUMMARY: assert property (faultPending == $past((|limitFlags) || (|shortFlags)))
    else $error("fault summary wrong");

  COV_STEPDOWN_FAULT: cover property (!detSync.stepUp && detSync.limit[0] ##1 limitFlags[0]);
  COV_STEPUP_FAULT: cover property (detSync.stepUp && detSync.limit[7] ##1 limitFlags[7]);
  COV_CLEAR: cover property (limitFlags[0] && wrLimit && !regWrData[0] ##1 !limitFlags[0]);
  COV_SET_BEATS_CLEAR: cover property (shortSet[0] && shortClr[0] ##1 shortFlags[0]);
  COV_PROTECTED_WRITE: cover property (regWrEn && writeProtect && hit(regAddr, blsfs_pkg::LIMIT_ADDR));

endmodule // blsfs_fault_status

`default_nettype wire

// ==== testbench/blsfs_host_model.sv ====
// Host model: system controller issuing byte register reads and writes.
// Assumes the block takes a request at a rising edge where its strobe is high.
`timescale 1ns/10ps
`default_nettype none

module blsfs_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] regAddr,
  output logic            regWrEn,
  output logic      [7:0] regWrData,
  output logic            regRdEn,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid
);
  // Idle port; lines not in use carry changing junk, never a stale value
  initial
  begin
    regAddr = 8'h5a;
    regWrEn = 1'b0;
    regWrData = 8'ha5;
    regRdEn = 1'b0;
  end

  // One write, strobe held to its taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    regWrData <= ~d;
    regAddr <= ~a;
  endtask

  // One read; waits a bounded time for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (regRdValid !== 1'b1 && n < 4);
    d = (regRdValid === 1'b1) ? regRdData : 8'hxx;
  endtask
endmodule // blsfs_host_model

`default_nettype wire

// ==== testbench/tb_top.sv ====
// Testbench for the fault status registers, with an integer model of the flags.
// Assumes the host model drives the register port and detectors are levels.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] limitDet;
  logic [4:0] shortDet;
  logic       stepUpMode;
  logic       writeProtect;
  logic [7:0] regAddr;
  logic       regWrEn;
  logic [7:0] regWrData;
  logic       regRdEn;
  logic [7:0] regRdData;
  logic       regRdValid;
  logic       faultPending;
  int         errCount = 0;
  int         cmpCount = 0;
  int         seed = 48;
  int         lim = 0;
  int         sht = 0;

  always #50 clk = ~clk;

  blsfs_fault_status dut_u (.clk, .resetn, .limitDet, .shortDet, .stepUpMode, .writeProtect,
    .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .regRdValid, .faultPending);
  blsfs_host_model hostU (.clk, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .regRdValid);

  task automatic reportAndStop();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    cmpCount++;
    if (g !== e)
    begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  // Reads both registers and the summary against the model
  task automatic checkAll();
    logic [7:0] d;
    hostU.rd(8'hd7, d);
    chk("limit", lim[7:0], d);
    hostU.rd(8'hd8, d);
    chk("short", sht[7:0], d);
    chk("faultPending", {7'h00, (lim | sht) != 0}, {7'h00, faultPending});
  endtask

  // Pulse detectors long enough to pass the synchronisers; only matching direction counts
  task automatic apply(input logic [7:0] l, input logic [4:0] s, input logic up);
    @(posedge clk);
    limitDet <= l;
    shortDet <= s;
    stepUpMode <= up;
    repeat (5) @(posedge clk);
    limitDet <= 8'h00;
    shortDet <= 5'h00;
    repeat (4) @(posedge clk);
    lim = lim | (l & (up ? 8'hbc : 8'h43));
    sht = sht | s;
  endtask

  // Writing zero clears, a one leaves the bit alone, protection blocks all
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    hostU.wr(a, d);
    if (writeProtect === 1'b0 && a == 8'hd7)
      lim = lim & d;
    if (writeProtect === 1'b0 && a == 8'hd8)
      sht = sht & d & 8'h1f;
  endtask

  // Main sequence
  initial
  begin
    logic [7:0] b;
    logic [7:0] d;
    limitDet = 8'h00;
    shortDet = 5'h00;
    stepUpMode = 1'b0;
    writeProtect = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    checkAll();
    for (int i = 0; i < 8; i++)
    begin
      b = 8'h01 << i;
      apply(b, 5'h00, ~|(b & 8'hbc));
      checkAll();
      apply(b, 5'h00, |(b & 8'hbc));
      checkAll();
    end
    for (int i = 0; i < 5; i++)
      apply(8'h00, 5'h01 << i, 1'b0);
    checkAll();
    @(posedge clk);
    writeProtect <= 1'b1;
    wrReg(8'hd7, 8'h00);
    checkAll();
    writeProtect <= 1'b0;
    wrReg(8'h00, 8'h00);
    wrReg(8'hd7, 8'hfe);
    wrReg(8'hd8, 8'he0);
    checkAll();
    hostU.rd(8'h00, d);
    chk("unmapped", 8'h00, d);
    repeat (6)
    begin
      apply($random(seed), $random(seed), $random(seed));
      checkAll();
      wrReg(8'hd7, $random(seed));
      wrReg(8'hd8, $random(seed));
      checkAll();
    end
    reportAndStop();
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    errCount++;
    reportAndStop();
  end
endmodule // tb_top

`default_nettype wire
